/* rtl/spr_serial_port.sv */
// Serial port with APB register access and edge interrupts.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module spr_serial_port #(
  parameter int unsigned CLK_HZ = spr_pkg::CLK_HZ_DEFAULT
) (
  input wire logic CLK_I, // 125 MHz clock
  input wire logic RESET_I, // Async reset, high
  input wire logic PSEL_I, // APB select
  input wire logic PENABLE_I, // APB enable
  input wire logic PWRITE_I, // APB write
  input wire logic [spr_pkg::APB_AW-1:0] PADDR_I, // APB address
  input wire logic [spr_pkg::APB_DW-1:0] PWDATA_I, // APB wdata
  output logic [spr_pkg::APB_DW-1:0] PRDATA_O, // APB rdata
  output logic PREADY_O, // APB ready
  output logic PSLVERR_O, // APB error
  input wire logic IO_LINE_SERIAL_IN_I, // Serial in
  output logic IO_LINE_SERIAL_OUT_O, // Serial out
  output logic IRQ_O // Interrupt level
);
  import spr_pkg::*;

  function automatic logic hit(input logic [APB_AW-1:0] a,
                               input logic [REG_W-1:0] idx);
    return a == {ADDR_TOP, idx, IDX_SHIFT};
  endfunction

  // Bit period minus one, from the block's own clock only.
  function automatic logic [CNT_W-1:0] bit_period(input spr_ctrl_t c);
    int unsigned p;
    p = CLK_HZ / BAUD_HZ[c.baud_select];
    if (c.prescale_by_eight) begin
      p = p * PRESCALE_FACTOR;
    end
    return CNT_W'(p - 1);
  endfunction

  // Register and bus state.
  spr_ctrl_t ctrl_r, ctrl_nxt;
  spr_flags_t flags_r, flags_nxt;
  spr_flags_t ist_r, ist_nxt;
  spr_flags_t imask_r, imask_nxt;
  logic [APB_DW-1:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic irq_r, irq_nxt;
  logic [DATA_BITS-1:0] hold_r, hold_nxt;

  // Transmit state.
  spr_line_state_t txs_r, txs_nxt;
  logic [DATA_BITS-1:0] tsh_r, tsh_nxt;
  logic [IDX_W-1:0] tix_r, tix_nxt;
  logic [CNT_W-1:0] tcnt_r, tcnt_nxt;
  logic tline_r, tline_nxt;
  logic tx_take;

  // Receive state.
  logic s1_r, s2_r, s3_r, rlvl_r, rlvl_nxt;
  spr_line_state_t rxs_r, rxs_nxt;
  logic [DATA_BITS-1:0] rsh_r, rsh_nxt;
  logic [DATA_BITS-1:0] rbyte_r, rbyte_nxt;
  logic [IDX_W-1:0] rix_r, rix_nxt;
  logic [CNT_W-1:0] rcnt_r, rcnt_nxt;
  logic rx_done;

  logic acc, done, wr, rd, mapped;

  // Registers and APB slave.
  always_comb begin
    acc = PSEL_I & PENABLE_I;
    done = acc & pready_r;
    wr = done & PWRITE_I;
    rd = done & ~PWRITE_I;
    mapped = hit(PADDR_I, IDX_CONTROL) | hit(PADDR_I, IDX_STATUS) |
             hit(PADDR_I, IDX_DATA) | hit(PADDR_I, IDX_IRQ_STATUS) |
             hit(PADDR_I, IDX_IRQ_MASK);
    pready_nxt = acc & ~pready_r;
    pslverr_nxt = pready_nxt & ~mapped;
    prdata_nxt = '0;
    if (pready_nxt & ~PWRITE_I) begin
      if (hit(PADDR_I, IDX_CONTROL)) begin
        prdata_nxt = APB_DW'(ctrl_r);
      end
      if (hit(PADDR_I, IDX_STATUS)) begin
        prdata_nxt = APB_DW'(flags_r);
      end
      if (hit(PADDR_I, IDX_DATA)) begin
        prdata_nxt = APB_DW'(rbyte_r);
      end
      if (hit(PADDR_I, IDX_IRQ_STATUS)) begin
        prdata_nxt = APB_DW'(ist_r);
      end
      if (hit(PADDR_I, IDX_IRQ_MASK)) begin
        prdata_nxt = APB_DW'(imask_r);
      end
    end
    ctrl_nxt = ctrl_r;
    imask_nxt = imask_r;
    hold_nxt = hold_r;
    flags_nxt = flags_r;
    ist_nxt = ist_r;
    if (wr & hit(PADDR_I, IDX_CONTROL)) begin
      ctrl_nxt = spr_ctrl_t'(PWDATA_I[$bits(spr_ctrl_t)-1:0]);
    end
    if (wr & hit(PADDR_I, IDX_IRQ_MASK)) begin
      imask_nxt = spr_flags_t'(PWDATA_I[$bits(spr_flags_t)-1:0]);
    end
    if (wr & hit(PADDR_I, IDX_IRQ_STATUS)) begin
      ist_nxt = ist_r & ~spr_flags_t'(PWDATA_I[$bits(spr_flags_t)-1:0]);
    end
    if (tx_take) begin
      flags_nxt.tx_buffer_empty = 1'b1;
    end
    if (wr & hit(PADDR_I, IDX_DATA)) begin
      hold_nxt = PWDATA_I[DATA_BITS-1:0];
      flags_nxt.tx_buffer_empty = 1'b0;
    end
    if (rd & hit(PADDR_I, IDX_DATA)) begin
      flags_nxt.rx_buffer_full = 1'b0;
    end
    if (rx_done) begin
      flags_nxt.rx_buffer_full = 1'b1;
    end
    // Events fire only on entry to full or empty; set beats clear.
    // A take that meets a new data write still counts as a transition.
    if (flags_nxt.rx_buffer_full & ~flags_r.rx_buffer_full) begin
      ist_nxt.rx_buffer_full = 1'b1;
    end
    if (tx_take) begin
      ist_nxt.tx_buffer_empty = 1'b1;
    end
    irq_nxt = |(ist_nxt & imask_nxt);
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ctrl_r <= CTRL_RESET;
      flags_r <= FLAGS_RESET;
      ist_r <= IRQ_RESET;
      imask_r <= IRQ_RESET;
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      irq_r <= 1'b0;
      hold_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      flags_r <= flags_nxt;
      ist_r <= ist_nxt;
      imask_r <= imask_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      irq_r <= irq_nxt;
      hold_r <= hold_nxt;
    end
  end

  // Transmitter: holding byte moves to the shifter, then framed out.
  always_comb begin
    txs_nxt = txs_r;
    tsh_nxt = tsh_r;
    tix_nxt = tix_r;
    tline_nxt = tline_r;
    tx_take = 1'b0;
    tcnt_nxt = (tcnt_r == '0) ? tcnt_r : tcnt_r - 1'b1;
    unique case (txs_r)
      LS_IDLE: begin
        tline_nxt = 1'b1;
        if (ctrl_r.enable & ~flags_r.tx_buffer_empty) begin
          tx_take = 1'b1;
          tsh_nxt = hold_r;
          tline_nxt = 1'b0;
          tcnt_nxt = bit_period(ctrl_r);
          txs_nxt = LS_START;
        end
      end
      LS_START: begin
        if (tcnt_r == '0) begin
          tline_nxt = tsh_r[0];
          tix_nxt = '0;
          tcnt_nxt = bit_period(ctrl_r);
          txs_nxt = LS_DATA;
        end
      end
      LS_DATA: begin
        if (tcnt_r == '0) begin
          tcnt_nxt = bit_period(ctrl_r);
          if (tix_r == IDX_W'(DATA_BITS - 1)) begin
            tline_nxt = 1'b1;
            txs_nxt = LS_STOP;
          end else begin
            tsh_nxt = tsh_r >> 1;
            tline_nxt = tsh_r[1];
            tix_nxt = tix_r + 1'b1;
          end
        end
      end
      LS_STOP: begin
        if (tcnt_r == '0) begin
          txs_nxt = LS_IDLE;
        end
      end
    endcase
    if (~ctrl_r.enable) begin
      txs_nxt = LS_IDLE;
      tline_nxt = 1'b1;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      txs_r <= LS_IDLE;
      tsh_r <= '0;
      tix_r <= '0;
      tcnt_r <= '0;
      tline_r <= 1'b1;
    end else begin
      txs_r <= txs_nxt;
      tsh_r <= tsh_nxt;
      tix_r <= tix_nxt;
      tcnt_r <= tcnt_nxt;
      tline_r <= tline_nxt;
    end
  end

  // Receiver: start is checked at mid-bit, bits sampled mid-bit.
  // Stop bit is not checked and nothing reports errors.
  always_comb begin
    rlvl_nxt = (s2_r == s3_r) ? s3_r : rlvl_r;
    rxs_nxt = rxs_r;
    rsh_nxt = rsh_r;
    rix_nxt = rix_r;
    rbyte_nxt = rbyte_r;
    rx_done = 1'b0;
    rcnt_nxt = (rcnt_r == '0) ? rcnt_r : rcnt_r - 1'b1;
    unique case (rxs_r)
      LS_IDLE: begin
        if (ctrl_r.enable & ~rlvl_r) begin
          rcnt_nxt = bit_period(ctrl_r) >> 1;
          rxs_nxt = LS_START;
        end
      end
      LS_START: begin
        if (rcnt_r == '0) begin
          rix_nxt = '0;
          rcnt_nxt = bit_period(ctrl_r);
          rxs_nxt = rlvl_r ? LS_IDLE : LS_DATA;
        end
      end
      LS_DATA: begin
        if (rcnt_r == '0) begin
          rsh_nxt = {rlvl_r, rsh_r[DATA_BITS-1:1]};
          rcnt_nxt = bit_period(ctrl_r);
          rix_nxt = rix_r + 1'b1;
          if (rix_r == IDX_W'(DATA_BITS - 1)) begin
            rxs_nxt = LS_STOP;
          end
        end
      end
      LS_STOP: begin
        if (rcnt_r == '0) begin
          rbyte_nxt = rsh_r;
          rx_done = 1'b1;
          rxs_nxt = LS_IDLE;
        end
      end
    endcase
    if (~ctrl_r.enable) begin
      rxs_nxt = LS_IDLE;
      rx_done = 1'b0;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      rlvl_r <= 1'b1;
      rxs_r <= LS_IDLE;
      rsh_r <= '0;
      rix_r <= '0;
      rcnt_r <= '0;
      rbyte_r <= '0;
    end else begin
      s1_r <= IO_LINE_SERIAL_IN_I;
      s2_r <= s1_r;
      s3_r <= s2_r;
      rlvl_r <= rlvl_nxt;
      rxs_r <= rxs_nxt;
      rsh_r <= rsh_nxt;
      rix_r <= rix_nxt;
      rcnt_r <= rcnt_nxt;
      rbyte_r <= rbyte_nxt;
    end
  end

  assign PRDATA_O = prdata_r;
  assign PREADY_O = pready_r;
  assign PSLVERR_O = pslverr_r;
  assign IRQ_O = irq_r;
  assign IO_LINE_SERIAL_OUT_O = tline_r;
endmodule // spr_serial_port
`default_nettype wire

/* rtl/spr_pkg.sv */
// Constants and types of the serial port register block.
// Summary of operation
// - Control register: enable, baud select, prescale.
// - Transmit and receive use two dedicated lines.
// - Status is read-only; upper bits read zero.
// - Status D1 receive full, D0 transmit empty.
// - Transmit empty sets when byte enters shifter.
// - No parity, framing or overrun reporting.
// - Write data address loads low transmit byte.
// - Read data address returns received byte.
// - Interrupts only on full/empty transitions.
// - Bit timing independent of general timers.
package spr_pkg;
  localparam int unsigned APB_AW = 32;
  localparam int unsigned APB_DW = 32;
  localparam int unsigned REG_W = 16;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned CNT_W = 20;
  localparam int unsigned IDX_W = 3;

  // Register indices; the byte address is four times the index.
  localparam logic [REG_W-1:0] IDX_CONTROL = 16'hc0e0;
  localparam logic [REG_W-1:0] IDX_STATUS = 16'hc0e2;
  localparam logic [REG_W-1:0] IDX_DATA = 16'hc0e4;
  localparam logic [REG_W-1:0] IDX_IRQ_STATUS = 16'hc0e6;
  localparam logic [REG_W-1:0] IDX_IRQ_MASK = 16'hc0e8;
  localparam logic [1:0] IDX_SHIFT = 2'h0;
  localparam logic [13:0] ADDR_TOP = 14'h0000;

  localparam int unsigned CLK_HZ_DEFAULT = 125_000_000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned PRESCALE_FACTOR = 8;
  localparam int unsigned BAUD_HZ [8] = '{
    115200, 57600, 38400, 28800, 19200, 14400, 9600, 7200
  };

  typedef struct packed {
    logic prescale_by_eight;
    logic [2:0] baud_select;
    logic enable;
  } spr_ctrl_t;

  // Same layout for status, interrupt status and interrupt mask.
  typedef struct packed {
    logic rx_buffer_full;
    logic tx_buffer_empty;
  } spr_flags_t;

  localparam spr_ctrl_t CTRL_RESET = '0;
  localparam spr_flags_t FLAGS_RESET = 2'h1;
  localparam spr_flags_t IRQ_RESET = 2'h0;

  typedef enum logic [1:0] {
    LS_IDLE,
    LS_START,
    LS_DATA,
    LS_STOP
  } spr_line_state_t;
endpackage : spr_pkg

/* verif/spr_serial_port_monitor.sv */
// Port checker for the serial port block.
`timescale 1ns/1ps
`default_nettype none
module spr_serial_port_chk (
  input wire logic CLK_I, // Clock
  input wire logic RESET_I, // Reset
  input wire logic PSEL_I, // APB select
  input wire logic PENABLE_I, // APB enable
  input wire logic PWRITE_I, // APB write
  input wire logic [31:0] PADDR_I, // APB address
  input wire logic [31:0] PRDATA_O, // APB rdata
  input wire logic PREADY_O, // APB ready
  input wire logic PSLVERR_O, // APB error
  input wire logic IO_LINE_SERIAL_OUT_O // Serial out
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  wire logic rd = PREADY_O && !PWRITE_I;
  a_ready_one_wait: assert property (
    PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O)
    else $error("Ready missing after one wait state.");
  a_ready_pulse: assert property (
    PREADY_O |=> !PREADY_O)
    else $error("Ready held too long.");
  a_ready_req: assert property (
    PREADY_O |-> PSEL_I && PENABLE_I)
    else $error("Ready without a request.");
  a_err_ready: assert property (
    PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0)
    else $error("Error without ready or with data.");
  a_rdata_idle: assert property (
    !PREADY_O |-> PRDATA_O == 32'h0)
    else $error("Read data outside a read answer.");
  a_ctl_upper: assert property (
    rd && PADDR_I == 32'h30380 |-> PRDATA_O[31:5] == 27'h0)
    else $error("Control reserved bits set.");
  a_stat_upper: assert property (
    rd && PADDR_I == 32'h30388 |-> PRDATA_O[31:2] == 30'h0)
    else $error("Status reserved bits set.");
  a_data_upper: assert property (
    rd && PADDR_I == 32'h30390 |-> PRDATA_O[31:8] == 24'h0)
    else $error("Receive data upper bits set.");
  a_start_hold: assert property (
    $fell(IO_LINE_SERIAL_OUT_O) |-> !IO_LINE_SERIAL_OUT_O [*8])
    else $error("Start bit too short.");
endmodule // spr_serial_port_chk
bind spr_serial_port spr_serial_port_chk u_chk (
  .CLK_I(CLK_I),
  .RESET_I(RESET_I),
  .PSEL_I(PSEL_I),
  .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I),
  .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O),
  .IO_LINE_SERIAL_OUT_O(IO_LINE_SERIAL_OUT_O)
);
`default_nettype wire

/* verif/spr_term.sv */
// Serial terminal model at the far end of the link.
`timescale 1ns/1ps
`default_nettype none
module spr_term (
  input wire logic clk_i, // Clock
  input wire logic line_i, // Line from the port
  input wire logic [31:0] bit_cyc_i, // Cycles per bit
  output logic line_o // Line to the port
);
  logic [7:0] got;
  logic stop_bit;
  int n_got;
  initial begin
    line_o = 1'b1;
    n_got = 0;
  end
  always begin
    @(negedge line_i);
    repeat (bit_cyc_i / 2) @(posedge clk_i);
    for (int i = 0; i < 9; i++) begin
      repeat (bit_cyc_i) @(posedge clk_i);
      if (i < 8) got[i] = line_i;
      else stop_bit = line_i;
    end
    n_got++;
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      line_o <= f[i];
      repeat (bit_cyc_i - 1) @(posedge clk_i);
    end
  endtask
endmodule // spr_term
`default_nettype wire

/* verif/tb_spr_serial_port.sv */
// Self-checking bench of the serial port block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_spr_serial_port;
  import spr_pkg::*;
  localparam int unsigned HZ = 1152000;
  localparam logic [31:0] A_CTL = 32'h30380, A_ST = 32'h30388;
  localparam logic [31:0] A_DAT = 32'h30390, A_IS = 32'h30398;
  localparam logic [31:0] A_IM = 32'h303a0;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
  logic pready, perr, tx, rx, irq;
  logic [31:0] paddr = '0, pwd = '0, prd, r;
  logic e;
  int bit_cyc = 10, mismatches = 0, check_count = 0, cyc = 0, n;
  always #4 clk = ~clk;
  spr_serial_port #(.CLK_HZ(HZ)) dut (.CLK_I(clk), .RESET_I(rst),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwd),
    .PRDATA_O(prd), .PREADY_O(pready), .PSLVERR_O(perr),
    .IO_LINE_SERIAL_IN_I(rx), .IO_LINE_SERIAL_OUT_O(tx), .IRQ_O(irq));
  spr_term term (.clk_i(clk), .line_i(tx), .bit_cyc_i(bit_cyc), .line_o(rx));
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 60000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic apb(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Ready and read data are taken at the rising edge that completes.
    do @(posedge clk); while (pready !== 1'b1);
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic rd_chk(input logic [31:0] a, exp);
    apb(0, a, 0);
    `CHK(r, exp)
  endtask
  task automatic t_regs();
    rd_chk(A_CTL, 32'h0); rd_chk(A_ST, 32'h1); rd_chk(A_IM, 32'h0);
    apb(1, A_CTL, 32'hffffffff); rd_chk(A_CTL, 32'h1f);
    apb(1, A_CTL, 32'h000b); rd_chk(A_CTL, 32'hb);
    apb(1, A_ST, 32'h0); rd_chk(A_ST, 32'h1);
    apb(0, 32'h0, 0); `CHK({e, r}, 33'h100000000)
  endtask
  task automatic t_tx(input int k, input logic p);
    bit_cyc = (HZ / BAUD_HZ[k]) * (p ? 8 : 1);
    n = term.n_got;
    apb(1, A_CTL, {27'h0, p, k[2:0], 1'b1});
    apb(1, A_DAT, 32'h1a5 ^ k);
    // The next byte may only be written once the holding buffer is empty.
    do apb(0, A_ST, 0); while (r[0] !== 1'b1 && cyc < 59000);
    rd_chk(A_IS, 32'h1);
    apb(1, A_IS, 32'h1);
    apb(1, A_DAT, 32'h5a);
    rd_chk(A_ST, 32'h0);
    rd_chk(A_IS, 32'h0);
    for (int i = 0; i < 2; i++) begin
      while (term.n_got == n + i && cyc < 59000) @(posedge clk);
      `CHK(term.got, i ? 8'h5a : 8'ha5 ^ k)
      `CHK(term.stop_bit, 1'b1)
    end
    rd_chk(A_IS, 32'h1);
    apb(1, A_IS, 32'h1);
  endtask
  task automatic t_rx();
    bit_cyc = 10;
    apb(1, A_CTL, 32'h1);
    apb(1, A_IS, 32'h3);
    term.send(8'h3c);
    repeat (20) @(posedge clk);
    rd_chk(A_ST, 32'h3);
    rd_chk(A_IS, 32'h2);
    `CHK(irq, 1'b0)
    apb(1, A_IM, 32'h2); apb(0, A_ST, 0); `CHK(irq, 1'b1)
    apb(1, A_IS, 32'h2); apb(0, A_ST, 0); `CHK(irq, 1'b0)
    rd_chk(A_DAT, 32'h3c); rd_chk(A_ST, 32'h1);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    `CHK({irq, tx}, 2'h1)
    t_regs();
    for (int k = 0; k < 8; k++) t_tx(k, 0);
    t_tx(0, 1);
    t_rx();
    end_sim();
  end
endmodule // tb_spr_serial_port
`default_nettype wire
